// ---- cold_fault_ctrl.sv ----
// Purpose: Cold temperature supervisor with command-code registers
// Assumes: temp_i shares the threshold encoding and is compared signed
// Notes:   Two-wire slave sampled by clk_i; words travel low byte first
//
// Notes on behaviour
// - Command 0x52 holds the 16-bit cold warning threshold, read and write.
// - Command 0x53 holds the 16-bit cold fault threshold, read and write.
// - Command 0x54 holds the cold fault action byte, read and write.
// - Action 00 ignores the fault; output keeps running.
// - Action 01 keeps running for the delay, then follows retry field 5:3 if fault persists.
// - Action 10 disables output at once, then follows retry field 5:3.
// - Action 11 disables output until a clearing action happens.
// - Clears: status bit write, clear-faults command, reset, off-then-on.
// - Retry field 000 makes no attempt; output stays off until cleared.
// - Codes 001-110 make that many attempts, then stay off until cleared.
// - Attempts are spaced by the selected delay times the time unit.
// - Code 111 retries forever until commanded off or another fault.
// - Delay field n means 2^n units, 1 to 128.
// - One time unit comes from the register at 0xD2.
// - Command 0x55 holds the 16-bit input surge fault threshold.
`timescale 1ns/10ps
module cold_fault_ctrl
  import cold_fault_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h40,
  parameter int         TICK     = TICK_CYC
) (
  input  wire logic        clk_i,         // Controller clock, 50 MHz
  input  wire logic        resetn_i,      // Synchronous reset, active low
  input  wire logic        scl_i,         // Bus clock pin
  input  wire logic        sda_i,         // Bus data pin level
  output logic             sda_o,         // Bus data drive value
  output logic             sda_oe_o,      // Bus data drive enable
  input  wire logic        ctrl_on_i,     // Remote on pin, high for on
  input  wire logic [15:0] temp_i,        // Measured temperature
  input  wire logic        other_fault_i, // Shutdown by another fault
  output logic             output_en_o,   // Converter output enable
  output logic             cold_warn_o,   // Warning status bit
  output logic             cold_fault_o   // Fault status bit
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  logic [2:0] sync_m_q;
  logic [2:0] sync_s_q;
  logic [1:0] sync_p_q;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sync_m_q <= 3'h7;
      sync_s_q <= 3'h7;
      sync_p_q <= 2'h3;
    end else begin
      sync_m_q <= {ctrl_on_i, sda_i, scl_i};
      sync_s_q <= sync_m_q;
      sync_p_q <= sync_s_q[1:0];
    end
  end

  wire scl_s     = sync_s_q[0];
  wire sda_s     = sync_s_q[1];
  wire scl_rise  = scl_s && !sync_p_q[0];
  wire scl_fall  = !scl_s && sync_p_q[0];
  wire start_c   = scl_s && sync_p_q[0] && sync_p_q[1] && !sda_s;
  wire stop_c    = scl_s && sync_p_q[0] && !sync_p_q[1] && sda_s;

  ////////////////////////////////////////////////////////////////////////
  // Byte-level slave
  logic [3:0]  bit_q;
  logic [1:0]  idx_q;
  logic        act_q;
  logic        tx_q;
  logic        oe_q;
  logic [7:0]  sh_q;
  logic [7:0]  lo_q;
  logic [7:0]  cmd_q;
  logic [7:0]  txsh_q;
  logic [15:0] rd_word;

  wire       byte_end = act_q && scl_fall && (bit_q == 4'h8);
  wire       ack_end  = act_q && scl_fall && (bit_q == 4'h9);
  wire       addr_hit = (sh_q[7:1] == DEV_ADDR);
  wire [7:0] tx_byte  = (idx_q == 2'h0) ? rd_word[7:0] : rd_word[15:8];
  wire       wr_cmd   = byte_end && !tx_q && (idx_q == 2'h1);
  wire       wr_lo    = byte_end && !tx_q && (idx_q == 2'h2);
  wire       wr_hi    = byte_end && !tx_q && (idx_q == 2'h3);
  wire       clr_cmd  = wr_cmd && (sh_q == CMD_CLEAR_FAULTS);

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      bit_q  <= 4'h0;
      idx_q  <= 2'h0;
      act_q  <= 1'b0;
      tx_q   <= 1'b0;
      oe_q   <= 1'b0;
      sh_q   <= 8'h00;
      txsh_q <= 8'h00;
    end else if (start_c) begin
      bit_q <= 4'h0;
      idx_q <= 2'h0;
      act_q <= 1'b1;
      tx_q  <= 1'b0;
      oe_q  <= 1'b0;
    end else if (stop_c) begin
      act_q <= 1'b0;
      tx_q  <= 1'b0;
      oe_q  <= 1'b0;
    end else if (act_q && scl_rise) begin
      bit_q <= 4'(bit_q + 4'h1);
      if (bit_q < 4'h8) begin
        sh_q <= {sh_q[6:0], sda_s};
      end else if (tx_q && sda_s) begin
        act_q <= 1'b0;
      end
    end else if (byte_end) begin
      if (tx_q) begin
        oe_q <= 1'b0;
      end else if (idx_q == 2'h0 && !addr_hit) begin
        act_q <= 1'b0;
      end else begin
        oe_q <= 1'b1;
        if (idx_q == 2'h0) begin
          tx_q <= sh_q[0];
        end
      end
    end else if (ack_end) begin
      bit_q  <= 4'h0;
      idx_q  <= (idx_q == 2'h3) ? 2'h3 : 2'(idx_q + 2'h1);
      txsh_q <= tx_byte;
      oe_q   <= tx_q && !tx_byte[7];
    end else if (act_q && scl_fall && tx_q && bit_q != 4'h0) begin
      txsh_q <= {txsh_q[6:0], 1'b0};
      oe_q   <= !txsh_q[6];
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = oe_q;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0] warn_q;
  logic [15:0] fault_q;
  logic [15:0] surge_q;
  action_t     action_q;
  logic [7:0]  op_q;
  logic [7:0]  unit_q;
  logic [7:0]  stat_q;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cmd_q <= 8'h00;
      lo_q  <= 8'h00;
    end else begin
      if (wr_cmd) begin
        cmd_q <= sh_q;
      end
      if (wr_lo) begin
        lo_q <= sh_q;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      warn_q  <= RST_COLD_WARN;
      fault_q <= RST_COLD_FAULT;
      surge_q <= RST_SURGE_FAULT;
    end else if (wr_hi) begin
      if (cmd_q == CMD_COLD_WARN) warn_q <= {sh_q, lo_q};
      if (cmd_q == CMD_COLD_FAULT) fault_q <= {sh_q, lo_q};
      if (cmd_q == CMD_SURGE_FAULT) surge_q <= {sh_q, lo_q};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      action_q <= action_t'(RST_COLD_ACTION);
      op_q     <= RST_OPERATION;
      unit_q   <= RST_TIME_UNIT;
    end else if (wr_lo) begin
      if (cmd_q == CMD_COLD_ACTION) action_q <= action_t'(sh_q);
      if (cmd_q == CMD_OPERATION) op_q <= sh_q;
      if (cmd_q == CMD_TIME_UNIT) unit_q <= sh_q;
    end
  end

  assign rd_word = (cmd_q == CMD_COLD_WARN)   ? warn_q :
                   (cmd_q == CMD_COLD_FAULT)  ? fault_q :
                   (cmd_q == CMD_COLD_ACTION) ? {8'h00, action_q} :
                   (cmd_q == CMD_SURGE_FAULT) ? surge_q :
                   (cmd_q == CMD_OPERATION)   ? {8'h00, op_q} :
                   (cmd_q == CMD_TIME_UNIT)   ? {8'h00, unit_q} :
                   (cmd_q == CMD_STATUS_TEMP) ? {8'h00, stat_q} : 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // Detection and status, set wins over clear
  wire       warn_now  = $signed(temp_i) < $signed(warn_q);
  wire       fault_now = $signed(temp_i) < $signed(fault_q);
  wire [7:0] stat_set  = {2'b00, warn_now, fault_now, 4'h0};
  wire [7:0] stat_clr  = (wr_lo && cmd_q == CMD_STATUS_TEMP) ? sh_q : 8'h00;
  wire       on_now    = sync_s_q[2] && op_q[OP_ON_BIT];
  logic      on_prev_q;
  wire       on_rise   = on_now && !on_prev_q;
  wire       clr_any   = clr_cmd || stat_clr[ST_FAULT_BIT] || on_rise;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      stat_q    <= 8'h00;
      on_prev_q <= 1'b1;
    end else begin
      stat_q    <= (clr_cmd ? 8'h00 : (stat_q & ~stat_clr)) | stat_set;
      on_prev_q <= on_now;
    end
  end

  assign cold_warn_o  = stat_q[ST_WARN_BIT];
  assign cold_fault_o = stat_q[ST_FAULT_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Fault response sequencer
  fault_st_t st_q;
  fault_st_t st_d;
  logic [2:0] tries_q;
  logic [2:0] tries_d;
  logic       t_start;
  logic       t_done;
  logic       out_q;
  wire        no_retry = (action_q.retries == RETRY_NONE);
  wire        endless  = (action_q.retries == RETRY_FOREVER);
  wire        used_up  = !endless && (4'(tries_q) + 4'h1 >= 4'(action_q.retries));

  always_comb begin
    st_d    = st_q;
    tries_d = tries_q;
    t_start = 1'b0;
    case (st_q)
      ST_RUN: begin
        tries_d = 3'h0;
        if (fault_now) begin
          case (action_q.resp)
            RESP_DELAY: begin
              st_d    = ST_DELAY;
              t_start = 1'b1;
            end
            RESP_RETRY: begin
              st_d    = no_retry ? ST_LATCHED : ST_RETRY;
              t_start = !no_retry;
            end
            RESP_LATCH: st_d = ST_LATCHED;
            default: st_d = ST_RUN;
          endcase
        end
      end
      ST_DELAY: begin
        if (t_done) begin
          st_d    = !fault_now ? ST_RUN : (no_retry ? ST_LATCHED : ST_RETRY);
          t_start = fault_now && !no_retry;
        end
      end
      ST_RETRY: begin
        if (other_fault_i || !on_now) begin
          st_d = ST_LATCHED;
        end else if (t_done) begin
          if (!fault_now) begin
            st_d    = ST_RUN;
            tries_d = 3'h0;
          end else if (used_up) begin
            st_d = ST_LATCHED;
          end else begin
            tries_d = endless ? tries_q : 3'(tries_q + 3'h1);
            t_start = 1'b1;
          end
        end
      end
      ST_LATCHED: st_d = ST_LATCHED;
      default: st_d = ST_RUN;
    endcase
    if (clr_any && st_q != ST_RUN) begin
      st_d    = ST_RUN;
      tries_d = 3'h0;
      t_start = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_q    <= ST_RUN;
      tries_q <= 3'h0;
      out_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      tries_q <= tries_d;
      out_q   <= on_now && (st_d == ST_RUN || st_d == ST_DELAY);
    end
  end

  assign output_en_o = out_q;

  delay_timer #(
    .TICK (TICK)
  ) u_delay (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .start_i  (t_start),
    .cfg_i    ({unit_q, action_q.delay}),
    .done_o   (t_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  AST_IGNORE: assert property (st_q == ST_RUN && action_q.resp == RESP_IGNORE |=> st_q == ST_RUN)
    else $error("ignore action left the run state");
  AST_DELAY_RUNS: assert property (st_q == ST_DELAY |-> output_en_o == $past(on_now))
    else $error("output dropped during the keep-running delay");
  AST_DISABLE_NOW: assert property (st_q == ST_RUN && fault_now && action_q.resp == RESP_RETRY
    && !clr_any |=> !output_en_o && st_q != ST_RUN)
    else $error("output not disabled at once on fault");
  AST_LATCH_HOLD: assert property (st_q == ST_LATCHED && !clr_any |=> st_q == ST_LATCHED && !output_en_o)
    else $error("latched fault released without a clear");
  AST_CLEAR: assert property (clr_any && st_q != ST_RUN |=> st_q == ST_RUN ##0 tries_q == 3'h0)
    else $error("clearing action did not release the fault");
  AST_NO_RETRY: assert property (st_q != ST_LATCHED && st_d == ST_RETRY |-> !no_retry)
    else $error("retry attempted with retry field zero");
  AST_RETRY_LIMIT: assert property (st_q == ST_RETRY && !endless |-> tries_q < action_q.retries)
    else $error("more restart attempts than programmed");
  AST_SPACING: assert property (st_q == ST_RETRY && tries_d != tries_q && st_d == ST_RETRY |-> t_done)
    else $error("restart attempt not at the end of a delay");
  AST_FOREVER: assert property (st_q == ST_RETRY && endless && t_done && fault_now && on_now
    && !other_fault_i && !clr_any |=> st_q == ST_RETRY)
    else $error("continuous retry stopped without cause");
  AST_SURGE_WR: assert property (wr_hi && cmd_q == CMD_SURGE_FAULT |=> surge_q == {$past(sh_q), $past(lo_q)})
    else $error("surge threshold word not stored");
  AST_STATUS: assert property (fault_now |=> cold_fault_o [*2])
    else $error("fault status not held while cold");
  AST_TRIES_RESET: assert property (st_q == ST_RUN |-> ##1 tries_q == 3'h0)
    else $error("attempt count not restarted");

  COV_LATCH: cover property (st_q == ST_RUN ##1 st_q == ST_LATCHED);
  COV_RETRY_OK: cover property (st_q == ST_RETRY ##1 st_q == ST_RUN);
  COV_DELAY_END: cover property (st_q == ST_DELAY && t_done);
  COV_READ: cover property (tx_q && byte_end);

endmodule

// ---- cold_fault_pkg.sv ----
// Purpose: Shared constants and types of the cold fault supervisor
// Assumes: 50 MHz controller clock
// Notes:   Command codes, field layouts, reset values, time unit counts
package cold_fault_pkg;

  localparam logic [7:0]  CMD_OPERATION    = 8'h01;
  localparam logic [7:0]  CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0]  CMD_COLD_WARN    = 8'h52;
  localparam logic [7:0]  CMD_COLD_FAULT   = 8'h53;
  localparam logic [7:0]  CMD_COLD_ACTION  = 8'h54;
  localparam logic [7:0]  CMD_SURGE_FAULT  = 8'h55;
  localparam logic [7:0]  CMD_STATUS_TEMP  = 8'h7D;
  localparam logic [7:0]  CMD_TIME_UNIT    = 8'hD2;

  localparam int          OP_ON_BIT        = 7;
  localparam int          ST_WARN_BIT      = 5;
  localparam int          ST_FAULT_BIT     = 4;

  localparam logic [15:0] RST_COLD_WARN    = 16'h0000;
  localparam logic [15:0] RST_COLD_FAULT   = 16'h0000;
  localparam logic [15:0] RST_SURGE_FAULT  = 16'hFFFF;
  localparam logic [7:0]  RST_COLD_ACTION  = 8'hC0;
  localparam logic [7:0]  RST_OPERATION    = 8'h80;
  localparam logic [7:0]  RST_TIME_UNIT    = 8'h00;

  localparam logic [2:0]  RETRY_NONE       = 3'b000;
  localparam logic [2:0]  RETRY_FOREVER    = 3'b111;

  // Base tick of the delay unit; register 0xD2 scales it by value+1
  localparam int          CLK_PERIOD_NS    = 20;
  localparam int          TIME_BASE_NS     = 1000;
  localparam int          TICK_CYC         = (TIME_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    RESP_IGNORE = 2'b00,
    RESP_DELAY  = 2'b01,
    RESP_RETRY  = 2'b10,
    RESP_LATCH  = 2'b11
  } resp_t;

  typedef struct packed {
    resp_t      resp;
    logic [2:0] retries;
    logic [2:0] delay;
  } action_t;

  typedef struct packed {
    logic [7:0] unit;
    logic [2:0] expo;
  } delay_cfg_t;

  typedef enum logic [1:0] {
    ST_RUN     = 2'b00,
    ST_DELAY   = 2'b01,
    ST_RETRY   = 2'b10,
    ST_LATCHED = 2'b11
  } fault_st_t;

endpackage

// ---- delay_timer.sv ----
// Purpose: One-shot delay of (unit+1) base ticks times 2^expo
// Assumes: start_i is a one-cycle pulse from the same clock
// Notes:   A new start restarts the count; done_o is a registered pulse
`timescale 1ns/10ps
module delay_timer
  import cold_fault_pkg::*;
#(
  parameter int TICK = TICK_CYC
) (
  input  wire logic       clk_i,    // Controller clock
  input  wire logic       resetn_i, // Synchronous reset, active low
  input  wire logic       start_i,  // Start pulse
  input  wire delay_cfg_t cfg_i,    // Unit scale and exponent
  output logic            done_o    // Expiry pulse
);

  localparam int PW = $clog2(TICK + 1);

  if (TICK < 1) begin : g_chk
    $error("TICK must be at least one cycle");
  end

  logic [PW-1:0] pre_q;
  logic [15:0]   cnt_q;
  logic [15:0]   tgt_q;
  logic          run_q;
  logic          done_q;
  wire           tick = run_q && (pre_q == PW'(TICK - 1));
  wire           last = tick && (cnt_q == tgt_q);
  wire  [15:0]   tgt  = 16'((({8'h00, cfg_i.unit} + 16'h0001) << cfg_i.expo) - 16'h0001);

  always_ff @(posedge clk_i) begin
    if (!resetn_i || start_i) begin
      pre_q <= '0;
      cnt_q <= 16'h0000;
    end else if (run_q) begin
      pre_q <= tick ? '0 : PW'(pre_q + 1'b1);
      if (tick) begin
        cnt_q <= 16'(cnt_q + 16'h0001);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      run_q  <= 1'b0;
      done_q <= 1'b0;
      tgt_q  <= 16'h0000;
    end else begin
      done_q <= last && !start_i;
      if (start_i) begin
        tgt_q <= tgt;
        run_q <= 1'b1;
      end else if (last) begin
        run_q <= 1'b0;
      end
    end
  end

  assign done_o = done_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  AST_TIMER_SPAN: assert property (start_i |=> 32'(tgt_q) + 32'h1 == (32'($past(cfg_i.unit)) + 32'h1)
    * (32'h1 << $past(cfg_i.expo)))
    else $error("delay span not 2^n units of the configured length");
  AST_TIMER_ONCE: assert property (done_o |-> !run_q)
    else $error("timer still running after expiry");

endmodule

// ---- bus_host.sv ----
// Purpose: Bus host model driving the two-wire command port of the supervisor
// Assumes: The bench joins host pull and device pull into one wire with a pull-up
// Notes:   Four controller cycles per bus clock phase, 160 ns per bit
`timescale 1ns/10ps
module bus_host (
  input  wire logic       clk_i,    // Controller clock
  input  wire logic       sda_i,    // Data wire level
  output logic            scl_o,    // Bus clock
  output logic            pull_o,   // High while pulling data low
  output logic [7:0]      rd_o,     // Last byte read
  output logic            rd_stb_o  // Pulse per byte read
);
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
    rd_o = 8'h00;
    rd_stb_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic q;
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  // Data moves in the low phase only, so no false start or stop is made
  task automatic bit_x(input logic b, output logic s);
    scl_o = 1'b0;
    q();
    pull_o = !b;
    q();
    scl_o = 1'b1;
    q();
    s = sda_i;
    q();
  endtask

  task automatic cond(input logic rep, input logic stp);
    if (rep || stp) begin
      scl_o = 1'b0;
      q();
      pull_o = !rep;
      q();
      scl_o = 1'b1;
      q();
    end
    pull_o = !stp;
    q();
    q();
  endtask

  task automatic tx(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(b[i], s);
    bit_x(1'b1, s);
  endtask

  // Last byte of a read is answered with a release, every other with a pull
  task automatic rx(input logic last);
    logic [7:0] v;
    logic       s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, s);
      v[i] = s;
    end
    bit_x(last, s);
    rd_o = v;
    rd_stb_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_stb_o = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Low byte first; n = 0 makes a send-byte command
  task automatic write(input logic [7:0] a, input logic [7:0] c, input logic [15:0] d, input int n);
    cond(1'b0, 1'b0);
    tx(a);
    tx(c);
    for (int i = 0; i < n; i++) tx(d[8*i+:8]);
    cond(1'b0, 1'b1);
  endtask

  task automatic read(input logic [7:0] c, input int n);
    cond(1'b0, 1'b0);
    tx(8'h80);
    tx(c);
    cond(1'b1, 1'b0);
    tx(8'h81);
    for (int i = 0; i < n; i++) rx(i == n - 1);
    cond(1'b0, 1'b1);
  endtask
endmodule

// ---- cold_fault_ctrl_tb_top.sv ----
// Purpose: Self-checking bench of the cold fault supervisor
// Assumes: Base tick shortened to four cycles; bus host model on the far side
// Notes:   Read bytes are checked from a queue of expected values
`timescale 1ns/10ps
module cold_fault_ctrl_tb_top;
  import cold_fault_pkg::*;
  localparam int          TK   = 4;
  localparam logic [15:0] WARM = 16'h0300;
  localparam logic [15:0] COLD = 16'hFF00;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        ctrl_on = 1'b1;
  logic        other_fault = 1'b0;
  logic [15:0] temp = WARM;
  logic [15:0] w;
  logic [7:0]  rd;
  logic        rd_stb;
  logic [7:0]  exp_q[$];
  logic [7:0]  cmds[3] = '{CMD_COLD_WARN, CMD_COLD_FAULT, CMD_SURGE_FAULT};
  wire         scl;
  wire         pull;
  wire         sda_oe;
  wire         sda_dev;
  wire         out_en;
  wire         warn;
  wire         fault;
  wire         sda_w = (sda_oe ? sda_dev : 1'b1) && !pull;
  int          fail_count = 0;
  int          tests_run = 0;
  int          d;
  int          c;

  always #10 clk = ~clk;

  cold_fault_ctrl #(.TICK(TK)) DUT (.clk_i(clk), .resetn_i(resetn), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_dev),
    .sda_oe_o(sda_oe), .ctrl_on_i(ctrl_on), .temp_i(temp), .other_fault_i(other_fault),
    .output_en_o(out_en), .cold_warn_o(warn), .cold_fault_o(fault));
  bus_host host (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .pull_o(pull), .rd_o(rd), .rd_stb_o(rd_stb));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (exp_q.size() != 0) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, exp_q.size(), 0);
    end
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // The strobe stands over exactly one rising edge, with the byte settled
  always @(posedge clk) begin
    if (rd_stb === 1'b1) begin
      if (exp_q.size() == 0)
        chk(16'h0000, 16'hFFFF);
      else
        chk({8'h00, rd}, {8'h00, exp_q.pop_front()});
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic expect_rd(input logic [7:0] cmd, input logic [15:0] v);
    exp_q.push_back(v[7:0]);
    exp_q.push_back(v[15:8]);
    host.read(cmd, 2);
  endtask

  task automatic put(input logic [7:0] cmd, input logic [7:0] v);
    host.write(8'h80, cmd, {8'h00, v}, 1);
  endtask

  task automatic wait_on(input int lim, output int n);
    n = 0;
    while (out_en !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
    if (n >= lim) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, out_en, 1'b1);
      give_verdict();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h2d79));
    tick(5);
    resetn = 1'b1;
    tick(6);
    chk(out_en, 1'b1);
    expect_rd(CMD_COLD_WARN, RST_COLD_WARN);
    expect_rd(CMD_COLD_FAULT, RST_COLD_FAULT);
    expect_rd(CMD_COLD_ACTION, {8'h00, RST_COLD_ACTION});
    expect_rd(CMD_SURGE_FAULT, RST_SURGE_FAULT);
    for (int i = 0; i < 3; i++) begin
      w = 16'($urandom());
      host.write(8'h80, cmds[i], w, 2);
      expect_rd(cmds[i], w);
    end
    // Foreign address and a short word must both leave the word alone
    host.write(8'h82, CMD_SURGE_FAULT, ~w, 2);
    host.write(8'h80, CMD_SURGE_FAULT, ~w, 1);
    expect_rd(CMD_SURGE_FAULT, w);
    w = 16'($urandom());
    put(CMD_COLD_ACTION, w[7:0]);
    expect_rd(CMD_COLD_ACTION, {8'h00, w[7:0]});
    host.write(8'h80, CMD_COLD_FAULT, 16'h0000, 2);
    host.write(8'h80, CMD_COLD_WARN, 16'h0200, 2);
    host.write(8'h80, CMD_CLEAR_FAULTS, 16'h0000, 0);
    temp = 16'h0150;
    tick(4);
    chk(warn, 1'b1);
    chk(fault, 1'b0);
    put(CMD_COLD_ACTION, 8'h00);
    temp = COLD;
    tick(20);
    chk(out_en, 1'b1);
    chk(fault, 1'b1);
    temp = WARM;
    // Latch off, then each way of clearing; odd passes latch through retry 000
    for (int k = 0; k < 5; k++) begin
      put(CMD_COLD_ACTION, k[0] ? 8'h80 : 8'hC0);
      temp = COLD;
      tick(3);
      chk(out_en, 1'b0);
      temp = WARM;
      tick(40);
      chk(out_en, 1'b0);
      case (k)
        0: put(CMD_STATUS_TEMP, 8'h10);
        1: host.write(8'h80, CMD_CLEAR_FAULTS, 16'h0000, 0);
        2: begin
          ctrl_on = 1'b0;
          tick(8);
          ctrl_on = 1'b1;
        end
        3: begin
          put(CMD_OPERATION, 8'h00);
          put(CMD_OPERATION, 8'h80);
        end
        default: begin
          resetn = 1'b0;
          tick(3);
          resetn = 1'b1;
        end
      endcase
      tick(8);
      chk(out_en, 1'b1);
      // Off-then-on frees the output but leaves the sticky status bit set
      chk(fault, (k == 2 || k == 3) ? 1'b1 : 1'b0);
    end
    put(CMD_TIME_UNIT, 8'h01);
    // One failed attempt, success on the second; repeated to see the count restart
    for (int n = 0; n < 4; n++) begin
      d = 2 * (1 << n) * TK;
      put(CMD_COLD_ACTION, {2'b10, 3'b010, n[2:0]});
      temp = COLD;
      tick(d + d / 2);
      temp = WARM;
      wait_on(4 * d, c);
      chk(c + d + d / 2 >= 2 * d && c + d + d / 2 <= 2 * d + 10, 1'b1);
    end
    put(CMD_COLD_ACTION, 8'h90);
    temp = COLD;
    tick(40);
    temp = WARM;
    tick(40);
    chk(out_en, 1'b0);
    host.write(8'h80, CMD_CLEAR_FAULTS, 16'h0000, 0);
    put(CMD_COLD_ACTION, 8'hB8);
    temp = COLD;
    tick(200);
    temp = WARM;
    wait_on(30, c);
    chk(out_en, 1'b1);
    temp = COLD;
    tick(20);
    other_fault = 1'b1;
    tick(2);
    other_fault = 1'b0;
    temp = WARM;
    tick(60);
    chk(out_en, 1'b0);
    host.write(8'h80, CMD_CLEAR_FAULTS, 16'h0000, 0);
    d = 2 * 4 * TK;
    put(CMD_COLD_ACTION, 8'h42);
    temp = COLD;
    tick(4);
    temp = WARM;
    tick(2 * d);
    chk(out_en, 1'b1);
    temp = COLD;
    tick(d - 4);
    chk(out_en, 1'b1);
    tick(12);
    chk(out_en, 1'b0);
    temp = WARM;
    tick(40);
    chk(out_en, 1'b0);
    give_verdict();
  end
endmodule
